// ==== dpsjm_pkg.sv ====
package dpsjm_pkg;

   // ----------------------------------------------------------------
   // Timing and divider limits
   // ----------------------------------------------------------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
   localparam int BASE_HZ       = 30_000_000;
   localparam int SPI1_MAX_HZ   = 2_066_000;
   localparam int SPI1_MIN_HZ   = 485_000;
   localparam int DIV_W         = 12;
   localparam int GAP_US_W      = 10;
   localparam int GAP_W         = 14;
   localparam logic [DIV_W-1:0] DIV_MIN = 12'h001;
   localparam logic [DIV_W-1:0] DIV_MAX = 12'hEA6;   // 3750
   // Port one limits: fastest rounds the divisor up, slowest down
   localparam logic [DIV_W-1:0] SPI1_DIV_MIN =
      DIV_W'((BASE_HZ + SPI1_MAX_HZ - 1) / SPI1_MAX_HZ);
   localparam logic [DIV_W-1:0] SPI1_DIV_MAX =
      DIV_W'(BASE_HZ / SPI1_MIN_HZ);

   // ----------------------------------------------------------------
   // Byte framing
   // ----------------------------------------------------------------
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 32;
   localparam logic [3:0] EDGE_LAST = 4'hF;   // 16 clock edges per byte

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      mode_off  = 4'h1,
      mode_jtag = 4'h2,
      mode_spi0 = 4'h4,
      mode_spi1 = 4'h8
   } dpsjm_mode_type;

   typedef enum logic [3:0] {
      st_idle  = 4'h1,
      st_lead  = 4'h2,
      st_shift = 4'h4,
      st_gap   = 4'h8
   } dpsjm_state_type;

   typedef struct packed {
      logic cpol;
      logic cpha;
      logic lsb_first;
   } dpsjm_cfg_type;

   localparam dpsjm_cfg_type CFG_RESET = '{cpol: 1'b0, cpha: 1'b0,
                                           lsb_first: 1'b0};

endpackage

// ==== dpsjm_fifo.sv ====
`timescale 1ns/100ps
module dpsjm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   // ----------------------------------------------------------------
   // Storage and pointers (depth must be a power of two)
   // ----------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   logic             push;
   logic             pop;

   // Handshakes
   assign push       = in_valid & in_ready;
   assign pop        = out_valid & out_ready;
   assign next_count = count + CW'(push) - CW'(pop);
   assign out_valid  = (count != '0);
   assign out_data   = mem[rd_ptr];

   // Occupancy; ready is registered so full is exact, never early
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count    <= '0;
         in_ready <= 1'b1;
      end else begin
         count    <= next_count;
         in_ready <= (next_count != CW'(DEPTH));
      end
   end

   // Pointers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
         if (pop)  rd_ptr <= AW'(rd_ptr + 1'b1);
      end
   end

   // Data array, no reset so it maps to RAM
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end

endmodule

// ==== dpsjm_master.sv ====
`timescale 1ns/100ps
module dpsjm_master #(
   parameter int GAP_MAX_US = 1000
) (
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              reset_n,
   // Configuration
   input  wire dpsjm_pkg::dpsjm_mode_type         port_mode,
   input  wire dpsjm_pkg::dpsjm_cfg_type          spi_cfg,
   input  wire logic [dpsjm_pkg::DIV_W-1:0]       clk_div,
   input  wire logic [dpsjm_pkg::GAP_US_W-1:0]    gap_us,
   input  wire logic                              jtag_two_wire,
   input  wire logic                              jtag_tms,
   input  wire logic                              jtag_tms_last,
   // Transmit stream
   input  wire logic [dpsjm_pkg::BYTE_W-1:0]      tx_data,
   input  wire logic                              tx_valid,
   output logic                                   tx_ready,
   // Receive stream and status
   output logic [dpsjm_pkg::BYTE_W-1:0]           rx_data,
   output logic                                   rx_valid,
   output logic                                   busy,
   // Target pins
   output logic                                   tck,
   output logic                                   tck_oe,
   output logic                                   tdi,
   output logic                                   tdi_oe,
   input  wire logic                              tms_in,
   output logic                                   tms,
   output logic                                   tms_oe,
   input  wire logic                              tdo
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int GAP_US_W = dpsjm_pkg::GAP_US_W;
   dpsjm_pkg::dpsjm_state_type               state;
   dpsjm_pkg::dpsjm_mode_type                act_mode;
   dpsjm_pkg::dpsjm_cfg_type                 act_cfg;
   logic [dpsjm_pkg::DIV_W-1:0]              act_div;
   logic [dpsjm_pkg::GAP_W-1:0]              act_gap;
   logic                                     act_two;
   logic [dpsjm_pkg::DIV_W-1:0]              div_cnt;
   logic [dpsjm_pkg::GAP_W-1:0]              gap_cnt;
   logic [3:0]                               edge_cnt;
   logic [dpsjm_pkg::BYTE_W-1:0]             cur_byte;
   logic [dpsjm_pkg::BYTE_W-1:0]             rx_sh;
   logic [dpsjm_pkg::BYTE_W-1:0]             fifo_data;
   logic                                     fifo_valid;
   logic                                     pop;
   logic                                     half_tick;
   logic                                     last_edge;
   logic                                     eff_cpha;
   logic                                     eff_cpol;
   logic                                     sample_now;
   logic                                     sample_in;
   logic                                     sdo;
   logic                                     cs_n;
   logic                                     done;
   logic                                     port_on;
   logic                                     is_spi;
   logic [dpsjm_pkg::GAP_US_W-1:0]           gap_lim;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [dpsjm_pkg::DIV_W-1:0] clamp_div(
      input logic [dpsjm_pkg::DIV_W-1:0] v,
      input logic [dpsjm_pkg::DIV_W-1:0] lo,
      input logic [dpsjm_pkg::DIV_W-1:0] hi);
      clamp_div = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // Bit index k of a byte, in the selected shift order
   function automatic logic pick_bit(
      input logic [dpsjm_pkg::BYTE_W-1:0] b,
      input logic [2:0]                   k,
      input logic                         lsb);
      pick_bit = lsb ? b[k] : b[3'h7 - k];
   endfunction

   // ----------------------------------------------------------------
   // Transmit FIFO
   // ----------------------------------------------------------------
   dpsjm_fifo #(
      .WIDTH (dpsjm_pkg::BYTE_W),
      .DEPTH (dpsjm_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (pop)
   );

   // ----------------------------------------------------------------
   // Derived controls
   // ----------------------------------------------------------------
   assign port_on   = (act_mode != dpsjm_pkg::mode_off);
   assign is_spi    = (act_mode == dpsjm_pkg::mode_spi0) |
                      (act_mode == dpsjm_pkg::mode_spi1);
   assign eff_cpha  = (act_mode == dpsjm_pkg::mode_spi1) &
                      act_cfg.cpha;
   assign eff_cpol  = is_spi & act_cfg.cpol;
   assign half_tick = (div_cnt == act_div - 1'b1);
   assign last_edge = (edge_cnt == dpsjm_pkg::EDGE_LAST);
   assign sample_now = (edge_cnt[0] == eff_cpha);
   assign sample_in = (act_two && act_mode == dpsjm_pkg::mode_jtag) ?
                      tms_in : tdo;
   assign gap_lim   = (gap_us > GAP_US_W'(GAP_MAX_US)) ?
                      GAP_US_W'(GAP_MAX_US) : gap_us;
   // Next byte taken from idle or at the end of a gap
   assign pop = fifo_valid & port_on &
                ((state == dpsjm_pkg::st_idle) |
                 (state == dpsjm_pkg::st_gap && gap_cnt == '0 &&
                  port_mode == act_mode));

   // Settings latch only between transfers; a bad or multi-hot select
   // turns every port off, so two ports can never run together
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         act_mode <= dpsjm_pkg::mode_off;
         act_cfg  <= dpsjm_pkg::CFG_RESET;
         act_div  <= dpsjm_pkg::DIV_MIN;
         act_gap  <= '0;
         act_two  <= 1'b0;
      end else if (state == dpsjm_pkg::st_idle) begin
         act_mode <= ($onehot(port_mode)) ? port_mode :
                     dpsjm_pkg::mode_off;
         act_cfg  <= spi_cfg;
         act_two  <= jtag_two_wire;
         act_gap  <= dpsjm_pkg::GAP_W'(gap_lim * dpsjm_pkg::CLK_PER_US);
         if (port_mode == dpsjm_pkg::mode_spi1)
            act_div <= clamp_div(clk_div, dpsjm_pkg::SPI1_DIV_MIN,
                                 dpsjm_pkg::SPI1_DIV_MAX);
         else
            act_div <= clamp_div(clk_div, dpsjm_pkg::DIV_MIN,
                                 dpsjm_pkg::DIV_MAX);
      end
   end

   // ----------------------------------------------------------------
   // Half-period divider, only running while a byte is framed
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         div_cnt <= '0;
      else if ((state == dpsjm_pkg::st_lead ||
                state == dpsjm_pkg::st_shift) && !half_tick)
         div_cnt <= div_cnt + 1'b1;
      else
         div_cnt <= '0;
   end

   // ----------------------------------------------------------------
   // Byte sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state    <= dpsjm_pkg::st_idle;
         edge_cnt <= '0;
         gap_cnt  <= '0;
         cur_byte <= '0;
         done     <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            dpsjm_pkg::st_idle: begin
               if (pop) begin
                  cur_byte <= fifo_data;
                  state    <= dpsjm_pkg::st_lead;
               end
            end
            dpsjm_pkg::st_lead: begin
               edge_cnt <= '0;
               if (half_tick) state <= dpsjm_pkg::st_shift;
            end
            dpsjm_pkg::st_shift: begin
               if (half_tick) begin
                  edge_cnt <= edge_cnt + 1'b1;
                  if (last_edge) begin
                     done    <= 1'b1;
                     gap_cnt <= act_gap;
                     state   <= dpsjm_pkg::st_gap;
                  end
               end
            end
            dpsjm_pkg::st_gap: begin
               if (gap_cnt != '0)
                  gap_cnt <= gap_cnt - 1'b1;
               else if (pop) begin
                  cur_byte <= fifo_data;
                  state    <= dpsjm_pkg::st_lead;
               end else
                  state <= dpsjm_pkg::st_idle;
            end
            default: state <= dpsjm_pkg::st_idle;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Serial clock, data out and data in
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tck   <= 1'b0;
         sdo   <= 1'b0;
         rx_sh <= '0;
      end else if (state == dpsjm_pkg::st_shift && half_tick) begin
         tck <= ~tck;
         if (sample_now)
            rx_sh[act_cfg.lsb_first ? edge_cnt[3:1] :
                  3'h7 - edge_cnt[3:1]] <= sample_in;
         else if (eff_cpha)
            sdo <= pick_bit(cur_byte, edge_cnt[3:1], act_cfg.lsb_first);
         else if (!last_edge)
            sdo <= pick_bit(cur_byte, 3'(edge_cnt[3:1] + 1'b1),
                            act_cfg.lsb_first);
      end else if (state != dpsjm_pkg::st_shift) begin
         // Idle level set ahead of the first edge
         tck <= eff_cpol;
         if (state == dpsjm_pkg::st_lead && !eff_cpha)
            sdo <= pick_bit(cur_byte, 3'h0, act_cfg.lsb_first);
      end
   end

   // Chip select spans bytes and gaps, released when the queue runs dry
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         cs_n <= 1'b1;
      else
         cs_n <= ~(is_spi & (pop | (state != dpsjm_pkg::st_idle &&
                   !(state == dpsjm_pkg::st_gap && gap_cnt == '0 &&
                     !pop))));
   end

   // ----------------------------------------------------------------
   // Pin registers and enables
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tdi    <= 1'b0;
         tms    <= 1'b1;
         tck_oe <= 1'b0;
         tdi_oe <= 1'b0;
         tms_oe <= 1'b0;
      end else begin
         tdi    <= sdo;
         tck_oe <= port_on;
         tms_oe <= port_on;
         tdi_oe <= port_on & ~(act_two & ~is_spi);
         if (is_spi)
            tms <= cs_n;
         else if (act_two)
            tms <= sdo;
         else if (state == dpsjm_pkg::st_shift && edge_cnt[3:1] == 3'h7)
            tms <= jtag_tms_last;
         else
            tms <= jtag_tms;
      end
   end

   // Receive byte and status
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_data  <= '0;
         rx_valid <= 1'b0;
         busy     <= 1'b0;
      end else begin
         rx_valid <= done;
         busy     <= (state != dpsjm_pkg::st_idle);
         if (done) rx_data <= rx_sh;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence byte_end;
      state == dpsjm_pkg::st_shift && half_tick && last_edge;
   endsequence

   sequence gap_entered;
      state == dpsjm_pkg::st_gap && gap_cnt == $past(act_gap);
   endsequence

   a_one_port: assert property ($onehot(act_mode))
      else $error("more than one port active");
   a_port0_phase: assert property (
      act_mode == dpsjm_pkg::mode_spi0 |-> !eff_cpha)
      else $error("port zero used clock phase one");
   a_port1_div: assert property (state != dpsjm_pkg::st_idle &&
      act_mode == dpsjm_pkg::mode_spi1 |->
      act_div >= dpsjm_pkg::SPI1_DIV_MIN &&
      act_div <= dpsjm_pkg::SPI1_DIV_MAX)
      else $error("port one divisor out of range");
   a_div_range: assert property (act_div >= dpsjm_pkg::DIV_MIN &&
      act_div <= dpsjm_pkg::DIV_MAX)
      else $error("divisor outside 1 to 3750");
   a_first_bit: assert property (state == dpsjm_pkg::st_shift &&
      $past(state) == dpsjm_pkg::st_lead && !eff_cpha |->
      sdo == (act_cfg.lsb_first ? cur_byte[0] : cur_byte[7]))
      else $error("first bit in wrong order");
   a_gap_load: assert property (byte_end |=> gap_entered)
      else $error("gap not loaded after byte");
   a_pins_float: assert property (act_mode == dpsjm_pkg::mode_off |=>
      !tck_oe && !tdi_oe && !tms_oe)
      else $error("pin driven with no port on");
   a_cs_frame: assert property (is_spi && state == dpsjm_pkg::st_lead
      |-> !cs_n ##1 !cs_n)
      else $error("chip select not low around byte");
   a_two_wire: assert property (act_mode == dpsjm_pkg::mode_jtag &&
      act_two |=> !tdi_oe)
      else $error("tdi driven in two-wire scan");

endmodule

// ==== dpsjm_target.sv ====
`timescale 1ns/100ps
module dpsjm_target (
   // Serial pins as the board sees them
   input  wire logic       sck,
   input  wire logic       sdi,
   input  wire logic       cs_n,
   output logic            sdo,
   // Mode and answer set by the bench
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       lsb_first,
   input  wire logic [7:0] reply
);
   // Bytes taken from the master, read by the bench
   logic [7:0] got[$];
   logic [7:0] rx_sh;
   logic       drv = 1'b1;
   int         n = 0;
   wire        s = sck ^ cpol;   // A rise of s is always the leading edge

   function automatic int idx(input int k);
      return lsb_first ? k : 7 - k;
   endfunction

   task automatic capture();
      rx_sh[idx(n)] = sdi;
      n++;
      if (n == 8) begin
         got.push_back(rx_sh);
         n = 0;
      end
   endtask

   // Deselected: the pull-up wins, never a stale bit
   assign sdo = cs_n ? 1'b1 : drv;

   // Phase 0 puts the first bit out as soon as it is selected
   always @(negedge cs_n) begin
      n = 0;
      if (!cpha) drv = reply[idx(0)];
   end
   // Phase 1 changes on the leading edge, phase 0 samples there
   always @(posedge s) if (!cs_n) begin
      if (cpha) drv = reply[idx(n)];
      else capture();
   end
   // The trailing edge does the opposite job
   always @(negedge s) if (!cs_n) begin
      if (cpha) capture();
      else drv = reply[idx(n)];
   end
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED %s expected %0h seen %0h", \
   nm, e, g); end end
module tb;
   // -----------------------------
   // Signals and stimulus table
   // -----------------------------
   typedef struct {
      dpsjm_pkg::dpsjm_mode_type mode;
      dpsjm_pkg::dpsjm_cfg_type  cfg;
      logic [11:0]               div;
      logic                      mcpha;
      logic [7:0]                tx;
      logic [7:0]                rep;
      int                        hp;
   } dpsjm_row_type;
   localparam int DLY = 10;
   logic                      clk = 1'b0;
   logic                      reset_n = 1'b0;
   dpsjm_pkg::dpsjm_mode_type port_mode = dpsjm_pkg::mode_off;
   dpsjm_pkg::dpsjm_cfg_type  spi_cfg = dpsjm_pkg::CFG_RESET;
   logic [11:0]               clk_div = 12'h002;
   logic [9:0]                gap_us = 10'h000;
   logic                      jtag_two_wire = 1'b0;
   logic                      jtag_tms = 1'b0;
   logic                      jtag_tms_last = 1'b0;
   logic                      tx_valid = 1'b0;
   logic                      m_cpha = 1'b0;
   logic [7:0]                tx_data = 8'h00;
   logic [7:0]                reply = 8'h00;
   logic [7:0]                rx_data;
   logic                      tx_ready, rx_valid, busy, tdo;
   logic                      tck, tck_oe, tdi, tdi_oe, tms, tms_oe;
   logic                      tck_d = 1'b1;
   logic                      cs_d = 1'b1;
   logic [7:0]                rx_q[$];
   int n_mismatch = 0, num_checks = 0;
   int run = 0, hp_seen = 0, max_run = 0, cs_rise = 0;
   dpsjm_row_type rows[8] = '{
      '{dpsjm_pkg::mode_spi0, 3'h0, 12'h002, 1'b0, 8'hA5, 8'h3C, 2},
      '{dpsjm_pkg::mode_spi0, 3'h5, 12'h003, 1'b0, 8'h96, 8'hC3, 3},
      '{dpsjm_pkg::mode_spi0, 3'h2, 12'h004, 1'b0, 8'h81, 8'h7E, 4},
      '{dpsjm_pkg::mode_spi1, 3'h3, 12'h004, 1'b1, 8'h5A, 8'hA5, 15},
      '{dpsjm_pkg::mode_spi1, 3'h6, 12'h064, 1'b1, 8'hF0, 8'h0F, 61},
      '{dpsjm_pkg::mode_spi1, 3'h5, 12'h014, 1'b0, 8'h12, 8'h34, 20},
      '{dpsjm_pkg::mode_spi1, 3'h0, 12'h01E, 1'b0, 8'h3C, 8'h99, 30},
      '{dpsjm_pkg::mode_jtag, 3'h1, 12'h002, 1'b0, 8'hE7, 8'h18, 2}};

   // Pins resolved with the weak pull-ups of the cable
   wire tck_w = tck_oe ? tck : 1'b1;
   wire tdi_w = tdi_oe ? tdi : 1'b1;
   wire tms_w = tms_oe ? tms : 1'b1;

   // -----------------------------
   // Design and board model
   // -----------------------------
   dpsjm_master #(.GAP_MAX_US(5)) u_dpsjm_master (
      .clk(clk), .reset_n(reset_n), .port_mode(port_mode),
      .spi_cfg(spi_cfg), .clk_div(clk_div), .gap_us(gap_us),
      .jtag_two_wire(jtag_two_wire), .jtag_tms(jtag_tms),
      .jtag_tms_last(jtag_tms_last), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .busy(busy), .tck(tck), .tck_oe(tck_oe),
      .tdi(tdi), .tdi_oe(tdi_oe), .tms_in(tms_w), .tms(tms),
      .tms_oe(tms_oe), .tdo(tdo));
   dpsjm_target u_dpsjm_target (
      .sck(tck_w), .sdi(tdi_w), .cs_n(tms_w), .sdo(tdo),
      .cpol(spi_cfg.cpol), .cpha(m_cpha),
      .lsb_first(spi_cfg.lsb_first), .reply(reply));

   // 10 MHz clock
   always #50 clk = ~clk;

   // Pin monitor: received bytes, half period, quiet runs, select rises
   always @(posedge clk) begin
      if (rx_valid === 1'b1) rx_q.push_back(rx_data);
      if (tck_w !== tck_d) hp_seen = run;
      if (tck_w !== tck_d || tms_w !== cs_d) run = 1;
      else run++;
      if (tms_w === 1'b0 && run > max_run) max_run = run;
      if (tms_w === 1'b1 && cs_d === 1'b0) cs_rise++;
      tck_d = tck_w;
      cs_d = tms_w;
   end

   // -----------------------------
   // Tasks
   // -----------------------------
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clk);
      #DLY;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Valid held high across the run, so no same-step toggling
   task automatic push_seq(input int k, input logic [7:0] b0);
      tx_valid = 1'b1;
      for (int i = 0; i < k; i++) begin
         tx_data = b0 + 8'(i);
         tick();
      end
      tx_valid = 1'b0;
   endtask

   task automatic wait_rx(input int k);
      for (int i = 0; i < 4000 && rx_q.size() < k; i++) tick();
      `CHK("rx count", k, rx_q.size())
   endtask

   task automatic chk_oe(input logic e);
      `CHK("tck_oe", e, tck_oe)
      `CHK("tdi_oe", e, tdi_oe)
      `CHK("tms_oe", e, tms_oe)
   endtask

   // Port change only lands while idle, so pass through off first
   task automatic setup(input dpsjm_pkg::dpsjm_mode_type m,
                        input dpsjm_pkg::dpsjm_cfg_type c,
                        input logic [11:0] d);
      port_mode = dpsjm_pkg::mode_off;
      spi_cfg = c;
      clk_div = d;
      tick(3);
      port_mode = m;
      rx_q.delete();
      u_dpsjm_target.got.delete();
      tick(3);
   endtask

   task automatic run_row(input dpsjm_row_type r);
      m_cpha = r.mcpha;
      reply = r.rep;
      setup(r.mode, r.cfg, r.div);
      chk_oe(1'b1);
      push_seq(1, r.tx);
      wait_rx(1);
      `CHK("rx_data", r.rep, rx_q[0])
      `CHK("sent", r.tx, u_dpsjm_target.got[0])
      `CHK("half period", r.hp, hp_seen)
      tick(20);
      port_mode = dpsjm_pkg::mode_off;
      tick(3);
      chk_oe(1'b0);
      $display("row done mode %0h div %0d", r.mode, r.div);
   endtask

   // -----------------------------
   // Main sequence and watchdog
   // -----------------------------
   initial begin
      tick(4);
      chk_oe(1'b0);
      reset_n = 1'b1;
      tick();
      foreach (rows[i]) run_row(rows[i]);
      // Two bytes in one burst, gap of 7 us clamped to 5
      m_cpha = 1'b0;
      gap_us = 10'h007;
      setup(dpsjm_pkg::mode_spi0, dpsjm_pkg::CFG_RESET, 12'h002);
      max_run = 0;
      cs_rise = 0;
      push_seq(2, 8'h40);
      wait_rx(2);
      tick(80);
      `CHK("select rises", 1, cs_rise)
      `CHK("gap run", 1'b1, max_run >= 50 && max_run <= 64)
      `CHK("second byte", 8'h41, u_dpsjm_target.got[1])
      $display("burst test done");
      // Fill the buffer with the port off, then drain it
      gap_us = 10'h000;
      port_mode = dpsjm_pkg::mode_off;
      tick(3);
      push_seq(32, 8'h00);
      tick(2);
      `CHK("full", 1'b0, tx_ready)
      push_seq(1, 8'hEE);
      `CHK("idle while off", 1'b0, busy)
      setup(dpsjm_pkg::mode_spi0, dpsjm_pkg::CFG_RESET, 12'h002);
      wait_rx(32);
      tick(20);
      `CHK("drained", 32, u_dpsjm_target.got.size())
      `CHK("last byte", 8'h1F, u_dpsjm_target.got[31])
      `CHK("space", 1'b1, tx_ready)
      $display("buffer test done");
      // A mode code that is not one-hot leaves all drivers off
      port_mode = dpsjm_pkg::mode_off;
      tick(3);
      port_mode = dpsjm_pkg::dpsjm_mode_type'(4'h6);
      tick(3);
      chk_oe(1'b0);
      $display("mode code test done");
      // Two-wire scan: only the master drives the data pin, so it reads
      // back its own byte, and the data-in driver must stay off
      jtag_two_wire = 1'b1;
      setup(dpsjm_pkg::mode_jtag, dpsjm_pkg::CFG_RESET, 12'h002);
      `CHK("tdi_oe two-wire", 1'b0, tdi_oe)
      `CHK("tms_oe two-wire", 1'b1, tms_oe)
      push_seq(1, 8'hC5);
      wait_rx(1);
      `CHK("loop back", 8'hC5, rx_q[0])
      tick(5);
      jtag_two_wire = 1'b0;
      $display("two-wire test done");
      // Reset in mid-byte releases every pin at once
      setup(dpsjm_pkg::mode_spi1, dpsjm_pkg::CFG_RESET, 12'h03D);
      push_seq(1, 8'h77);
      tick(100);
      reset_n = 1'b0;
      tick();
      chk_oe(1'b0);
      `CHK("busy in reset", 1'b0, busy)
      reset_n = 1'b1;
      $display("reset test done");
      end_of_test();
   end

   // Run needs well under 40000 cycles
   initial begin
      #4_000_000;
      n_mismatch++;
      end_of_test();
   end
endmodule
